// >>> core/tcr_consts.vh
// Constants for the transceiver configuration register bank
`ifndef TCR_CONSTS_VH
`define TCR_CONSTS_VH

`define TCR_REG_W 13
`define TCR_NUM_REGS 8
`define TCR_IDX_W 3
`define TCR_IDX_MAIN 3'h0
`define TCR_IDX_PRESC 3'h1
`define TCR_IDX_C 3'h2
`define TCR_IDX_D 3'h3
`define TCR_IDX_F 3'h5
`define TCR_ADDR_W 8
`define TCR_STATUS_ADDR 8'h20
`define TCR_MAIN_RST 13'h002a
`define TCR_B_RST 13'h0000
`define TCR_C_RST 13'h0050
`define TCR_GEN_RST 13'h0000
`define TCR_RESP_OKAY 2'h0
`define TCR_RESP_SLVERR 2'h2

`define TCR_BIT_SLEEP 12
`define TCR_BIT_DIR 11
`define TCR_SEL_HI 10
`define TCR_SEL_LO 8
`define TCR_PAMID_HI 7
`define TCR_PAMID_LO 6
`define TCR_LNA_HI 5
`define TCR_LNA_LO 4
`define TCR_MIX_HI 3
`define TCR_MIX_LO 2
`define TCR_LO_HI 1
`define TCR_LO_LO 0
`define TCR_BIT_PBIAS 12
`define TCR_BIT_DZ 11
`define TCR_SWAL_HI 10
`define TCR_SWAL_LO 7
`define TCR_MAIN_HI 6
`define TCR_MAIN_LO 0
`define TCR_BIT_PA4 8
`define TCR_PALO_HI 12
`define TCR_PALO_LO 11
`define TCR_BIT_DEMTOP 8
`define TCR_DEM_HI 8
`define TCR_DEM_LO 6

`define TCR_SEL_NORMAL 3'h0
`define TCR_SEL_VCO_NOMOD 3'h1
`define TCR_SEL_VCO_MOD 3'h2
`define TCR_SEL_REFDIV 3'h3
`define TCR_SEL_TXMOD 3'h4
`define TCR_SEL_PRESC_A 3'h5
`define TCR_SEL_PRESC_B 3'h6
`define TCR_SEL_SHIFT 3'h7

`endif

// >>> core/tcr_config_regs.v
// Configuration register bank with AXI4-Lite slave and lock pin test mux
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "tcr_consts.vh"

// Behaviour
// - Eight 13-bit registers, 3-bit address select
// - Main bit 12 puts chip asleep
// - Test selector valid only when demod top 0
// - Codes 1,2 show divided oscillator; modulation off for 1, on for 2
// - Code 3 shows reference divider output
// - Code 4 tx data drives modulation control
// - Codes 5,6 show prescaler, modulation off
// - Code 7 shows shift register data
// - Gain word gathered from three registers
// - Front end bias bits 5:4, default 10
// - Mixer bias bits 3:2, default 10
// - Oscillator swing bits 1:0, default 10
// - Second register bit 12 selects prescaler bias
// - Demod field top bit hands over lock pin
module tcr_config_regs #(
    parameter REG_W = `TCR_REG_W
) (
    input wire aclk,
    input wire aresetn,
    input wire [`TCR_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`TCR_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire vco_div_sig,
    input wire ref_div_sig,
    input wire dual_mod_sig,
    input wire tx_data_pin,
    input wire presc_sig,
    input wire shift_data_sig,
    input wire demod_test_sig,
    input wire lock_detect_sig,
    output reg lock_pin,
    output reg modulation_ctrl,
    output reg swallow_mod_en,
    output reg chip_sleep_bit,
    output reg direction_select,
    output reg [4:0] amplifier_gain_word,
    output reg [1:0] front_end_bias,
    output reg [1:0] mixer_bias,
    output reg [1:0] oscillator_swing,
    output reg prescaler_bias_source,
    output reg [1:0] dead_zone_pulse_width,
    output reg [3:0] swallow_count,
    output reg [6:0] main_div_count,
    output reg [2:0] demod_test_field
);

    wire [REG_W-1:0] cfg_reg [0:`TCR_NUM_REGS-1];
    reg [`TCR_ADDR_W-1:0] aw_addr_reg;
    reg aw_held_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_held_reg;
    wire [`TCR_NUM_REGS-1:0] written_reg;

    wire [`TCR_ADDR_W-1:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire wr_fire;
    wire wr_hit;
    wire [`TCR_IDX_W-1:0] wr_idx;
    wire [REG_W-1:0] main_r;
    wire [REG_W-1:0] presc_r;
    wire [REG_W-1:0] reg_c;
    wire [REG_W-1:0] reg_d;
    wire [REG_W-1:0] reg_f;
    wire [2:0] test_sel;

    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    assign wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
    assign wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
    assign wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
    assign wr_fire = (aw_held_reg || (s_axi_awvalid && s_axi_awready))
        && (w_held_reg || (s_axi_wvalid && s_axi_wready));
    assign wr_hit = (wr_addr[`TCR_ADDR_W-1:5] == 3'h0);
    assign wr_idx = wr_addr[4:2];

    // Address and data may arrive in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            aw_addr_reg <= {`TCR_ADDR_W{1'b0}};
            w_data_reg <= 32'h0;
            w_strb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TCR_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `TCR_RESP_OKAY : `TCR_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_reg <= 1'b1;
                    aw_addr_reg <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_reg <= 1'b1;
                    w_data_reg <= s_axi_wdata;
                    w_strb_reg <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `TCR_NUM_REGS; gi = gi + 1) begin : g_reg
            // One driver per entry keeps each slice in its own process
            wire [REG_W-1:0] rst_val;
            reg [REG_W-1:0] val_reg;
            reg done_reg;
            assign rst_val = (gi == 0) ? `TCR_MAIN_RST :
                (gi == 1) ? `TCR_B_RST :
                (gi == 2) ? `TCR_C_RST : `TCR_GEN_RST;
            assign cfg_reg[gi] = val_reg;
            assign written_reg[gi] = done_reg;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    val_reg <= rst_val;
                    done_reg <= 1'b0;
                end else if (wr_fire && wr_hit && wr_idx == gi) begin
                    if (wr_strb[0]) begin
                        val_reg[7:0] <= wr_data[7:0];
                    end
                    if (wr_strb[1]) begin
                        val_reg[REG_W-1:8] <= wr_data[REG_W-1:8];
                    end
                    done_reg <= 1'b1;
                end
            end
        end
    endgenerate

    // Registers read back as written; reads return state, status bit 9 lock
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `TCR_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr[`TCR_ADDR_W-1:5] == 3'h0) begin
                s_axi_rdata <= {19'h0, cfg_reg[s_axi_araddr[4:2]]};
                s_axi_rresp <= `TCR_RESP_OKAY;
            end else if (s_axi_araddr == `TCR_STATUS_ADDR) begin
                s_axi_rdata <= {22'h0, lock_pin, written_reg, chip_sleep_bit};
                s_axi_rresp <= `TCR_RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= `TCR_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    assign main_r = cfg_reg[`TCR_IDX_MAIN];
    assign presc_r = cfg_reg[`TCR_IDX_PRESC];
    assign reg_c = cfg_reg[`TCR_IDX_C];
    assign reg_d = cfg_reg[`TCR_IDX_D];
    assign reg_f = cfg_reg[`TCR_IDX_F];
    assign test_sel = main_r[`TCR_SEL_HI:`TCR_SEL_LO];

    // Field outputs registered so they never glitch
    always @(posedge aclk) begin
        if (!aresetn) begin
            chip_sleep_bit <= 1'b0;
            direction_select <= 1'b0;
            amplifier_gain_word <= 5'h0;
            front_end_bias <= 2'h2;
            mixer_bias <= 2'h2;
            oscillator_swing <= 2'h2;
            prescaler_bias_source <= 1'b0;
            dead_zone_pulse_width <= 2'h0;
            swallow_count <= 4'h0;
            main_div_count <= 7'h0;
            demod_test_field <= 3'h0;
        end else begin
            chip_sleep_bit <= main_r[`TCR_BIT_SLEEP];
            direction_select <= main_r[`TCR_BIT_DIR];
            amplifier_gain_word <= {reg_c[`TCR_BIT_PA4],
                main_r[`TCR_PAMID_HI:`TCR_PAMID_LO], reg_d[`TCR_PALO_HI:`TCR_PALO_LO]};
            front_end_bias <= main_r[`TCR_LNA_HI:`TCR_LNA_LO];
            mixer_bias <= main_r[`TCR_MIX_HI:`TCR_MIX_LO];
            oscillator_swing <= main_r[`TCR_LO_HI:`TCR_LO_LO];
            prescaler_bias_source <= presc_r[`TCR_BIT_PBIAS];
            dead_zone_pulse_width <= {presc_r[`TCR_BIT_DZ], 1'b0};
            swallow_count <= presc_r[`TCR_SWAL_HI:`TCR_SWAL_LO];
            main_div_count <= presc_r[`TCR_MAIN_HI:`TCR_MAIN_LO];
            demod_test_field <= reg_f[`TCR_DEM_HI:`TCR_DEM_LO];
        end
    end

    // Lock pin mux; registered, adds one cycle of latency
    always @(posedge aclk) begin
        if (!aresetn) begin
            lock_pin <= 1'b0;
            modulation_ctrl <= 1'b0;
            swallow_mod_en <= 1'b1;
        end else if (reg_f[`TCR_BIT_DEMTOP]) begin
            lock_pin <= demod_test_sig;
            modulation_ctrl <= dual_mod_sig;
            swallow_mod_en <= 1'b1;
        end else begin
            case (test_sel)
                `TCR_SEL_NORMAL: begin
                    lock_pin <= lock_detect_sig;
                    modulation_ctrl <= dual_mod_sig;
                    swallow_mod_en <= 1'b1;
                end
                `TCR_SEL_VCO_NOMOD: begin
                    lock_pin <= vco_div_sig;
                    modulation_ctrl <= dual_mod_sig;
                    swallow_mod_en <= 1'b0;
                end
                `TCR_SEL_VCO_MOD: begin
                    lock_pin <= vco_div_sig;
                    modulation_ctrl <= dual_mod_sig;
                    swallow_mod_en <= 1'b1;
                end
                `TCR_SEL_REFDIV: begin
                    lock_pin <= ref_div_sig;
                    modulation_ctrl <= dual_mod_sig;
                    swallow_mod_en <= 1'b1;
                end
                `TCR_SEL_TXMOD: begin
                    lock_pin <= tx_data_pin;
                    modulation_ctrl <= tx_data_pin;
                    swallow_mod_en <= 1'b1;
                end
                `TCR_SEL_PRESC_A, `TCR_SEL_PRESC_B: begin
                    lock_pin <= presc_sig;
                    modulation_ctrl <= dual_mod_sig;
                    swallow_mod_en <= 1'b0;
                end
                `TCR_SEL_SHIFT: begin
                    lock_pin <= shift_data_sig;
                    modulation_ctrl <= dual_mod_sig;
                    swallow_mod_en <= 1'b1;
                end
                default: begin
                    lock_pin <= lock_detect_sig;
                    modulation_ctrl <= dual_mod_sig;
                    swallow_mod_en <= 1'b1;
                end
            endcase
        end
    end

endmodule // tcr_config_regs

// >>> testbench/tcr_config_regs_checker.sv
// Assertion checker for the configuration register bank
`timescale 1ns/1ns
module tcr_config_regs_checker (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire demod_test_sig,
    input wire lock_pin,
    input wire chip_sleep_bit,
    input wire direction_select,
    input wire [4:0] amplifier_gain_word,
    input wire [1:0] front_end_bias,
    input wire [1:0] mixer_bias,
    input wire [1:0] oscillator_swing,
    input wire [1:0] dead_zone_pulse_width,
    input wire [3:0] swallow_count,
    input wire [6:0] main_div_count,
    input wire [2:0] demod_test_field
);
    // Only writes whose two channels meet on one edge are tracked
    wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire wr_main = wr_go && s_axi_awaddr == 8'h00;
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_sleep_write: assert property (wr_main && s_axi_wstrb[1] |-> ##2
        chip_sleep_bit == $past(s_axi_wdata[12], 2)) else $error("sleep bit wrong");
    a_dir_write: assert property (wr_main && s_axi_wstrb[1] |-> ##2
        direction_select == $past(s_axi_wdata[11], 2)) else $error("direction wrong");
    a_bias_write: assert property (wr_main && s_axi_wstrb[0] |-> ##2
        {front_end_bias, mixer_bias, oscillator_swing} == $past(s_axi_wdata[5:0], 2))
        else $error("bias fields wrong");
    a_count_write: assert property (wr_go && s_axi_awaddr == 8'h04 && &s_axi_wstrb[1:0]
        |-> ##2 {swallow_count, main_div_count} == $past(s_axi_wdata[10:0], 2))
        else $error("counter fields wrong");
    a_gain_low: assert property (wr_go && s_axi_awaddr == 8'h0c && s_axi_wstrb[1]
        |-> ##2 amplifier_gain_word[1:0] == $past(s_axi_wdata[12:11], 2))
        else $error("gain low bits wrong");
    a_dz_fixed: assert property (dead_zone_pulse_width[0] == 1'b0)
        else $error("dead zone low bit set");
    a_demod_route: assert property (demod_test_field[2] |->
        lock_pin == $past(demod_test_sig)) else $error("demod route wrong");
    a_write_answer: assert property (wr_go |=> s_axi_bvalid)
        else $error("no write response");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read response");
endmodule // tcr_config_regs_checker

bind tcr_config_regs tcr_config_regs_checker u_chk (.*);

// >>> testbench/transceiver_config_registers_bench.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ns
module transceiver_config_registers_bench;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, src = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, rd;
    logic [3:0] s_axi_wstrb = 4'h0;
    wire lock_detect_sig = src[0], vco_div_sig = src[1], dual_mod_sig = src[2];
    wire ref_div_sig = src[3], tx_data_pin = src[4], presc_sig = src[5];
    wire demod_test_sig = src[6], shift_data_sig = src[7];
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lock_pin;
    wire [1:0] s_axi_bresp, s_axi_rresp, front_end_bias, mixer_bias, oscillator_swing;
    wire [1:0] dead_zone_pulse_width;
    wire [31:0] s_axi_rdata;
    wire modulation_ctrl, swallow_mod_en, chip_sleep_bit, direction_select, prescaler_bias_source;
    wire [4:0] amplifier_gain_word;
    wire [3:0] swallow_count;
    wire [6:0] main_div_count;
    wire [2:0] demod_test_field;
    wire [29:0] obs = {chip_sleep_bit, direction_select, amplifier_gain_word, front_end_bias,
        mixer_bias, oscillator_swing, prescaler_bias_source, dead_zone_pulse_width,
        swallow_count, main_div_count, demod_test_field};
    integer n_mismatch = 0, n_tests = 0, cyc = 0, i, j;
    logic [12:0] sh [8];
    logic [1:0] resp;
    logic [2:0] ri [11] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h1, 3'h5};
    logic [12:0] rv [11] = '{13'h1555, 13'h1fff, 13'h0100, 13'h1800, 13'h0aaa, 13'h01c0,
        13'h1234, 13'h0fff, 13'h0aaa, 13'h0000, 13'h0000};
    // Source bit that each selector code should reach
    logic [2:0] smap [8] = '{3'h0, 3'h1, 3'h1, 3'h3, 3'h4, 3'h5, 3'h5, 3'h7};

    tcr_config_regs u_dut (.*);

    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    function logic [29:0] expo();
        expo = {sh[0][12:11], sh[2][8], sh[0][7:6], sh[3][12:11], sh[0][5:0], sh[1][12:11],
            1'b0, sh[1][10:0], sh[5][8:6]};
    endfunction

    // Ready is looked at on the falling edge, so it matches the next rising edge
    task axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        fork
            begin
                do @(negedge aclk); while (!s_axi_awready);
                @(posedge aclk);
                s_axi_awvalid <= 1'b0;
            end
            begin
                do @(negedge aclk); while (!s_axi_wready);
                @(posedge aclk);
                s_axi_wvalid <= 1'b0;
            end
        join
        do @(negedge aclk); while (!s_axi_bvalid);
        resp = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task axr(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        resp = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    task do_reset();
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        sh = '{13'h002a, 13'h0, 13'h0050, 13'h0, 13'h0, 13'h0, 13'h0, 13'h0};
        @(negedge aclk);
        chk(obs, expo(), "reset fields");
        chk(swallow_mod_en, 1'b1, "reset modulation");
        axr(8'h00);
        chk(rd, 32'h002a, "reset main");
        $display("reset test done");
    endtask

    task stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        do_reset();
        for (i = 0; i < 11; i++) begin
            axw({3'h0, ri[i], 2'h0}, {19'h0, rv[i]});
            chk(resp, 2'h0, "write response");
            sh[ri[i]] = rv[i];
            axr({3'h0, ri[i], 2'h0});
            chk(rd, {19'h0, rv[i]}, "readback");
            chk(obs, expo(), "fields");
        end
        $display("row table done");
        // Each selector code: its source high, then every other source high
        for (i = 0; i < 8; i++) begin
            axw(8'h00, {19'h0, i[2:0], 8'h2a});
            for (j = 0; j < 2; j++) begin
                @(posedge aclk);
                src <= j ? ~(8'h01 << smap[i]) : 8'h01 << smap[i];
                repeat (2) @(posedge aclk);
                @(negedge aclk);
                chk(lock_pin, !j, "lock pin");
                chk(modulation_ctrl, i == 4 ? src[4] : src[2], "modulation");
                chk(swallow_mod_en, !(i == 1 || i == 5 || i == 6), "swallow");
            end
        end
        axw(8'h14, 32'h0100);
        @(posedge aclk);
        src <= 8'h40;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk(lock_pin, 1'b1, "demod lock pin");
        $display("lock mux test done");
        axw(8'h80, 32'h1fff);
        chk(resp, 2'h2, "bad write response");
        axr(8'h40);
        chk(resp, 2'h2, "bad read response");
        axr(8'h00);
        chk(rd, 32'h072a, "main after bad write");
        axr(8'h20);
        chk(rd, 32'h03fe, "status word");
        $display("unmapped test done");
        do_reset();
        stop_test();
    end
endmodule // transceiver_config_registers_bench
